// file: inc/periph_reset_pkg.sv
// Package for the peripheral reset control block: offsets, bit positions, masks.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package periph_reset_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_WIDTH = 8;
  localparam logic [7:0] LOW_SPEED_BUS_UNIT_RESET_OFFSET = 8'h0C;
  localparam logic [7:0] SLOW_BUS_UNIT_RESET_OFFSET      = 8'h10;
  localparam logic [31:0] REG_RESET_VALUE                = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ_VALUE            = 32'h0000_0000;

  // Writable bits; reserved bits stay zero and read as zero
  localparam logic [31:0] LOW_SPEED_WRITE_MASK = 32'h0038_7FFD;
  localparam logic [31:0] SLOW_WRITE_MASK      = 32'h3E7E_C9FF;

  // ****************************************************************
  // Second-bus register fields
  // ****************************************************************
  localparam int unsigned ALT_FUNCTION_BIT = 0;
  localparam int unsigned PORT_A_BIT       = 2;
  localparam int unsigned PORT_B_BIT       = 3;
  localparam int unsigned PORT_C_BIT       = 4;
  localparam int unsigned PORT_D_BIT       = 5;
  localparam int unsigned PORT_E_BIT       = 6;
  localparam int unsigned PORT_F_BIT       = 7;
  localparam int unsigned PORT_G_BIT       = 8;
  localparam int unsigned CONVERTER_ZERO_BIT = 9;
  localparam int unsigned CONVERTER_ONE_BIT  = 10;
  localparam int unsigned TIMER_ZERO_BIT   = 11;
  localparam int unsigned SPI_ZERO_BIT     = 12;
  localparam int unsigned TIMER_SEVEN_BIT  = 13;
  localparam int unsigned SERIAL_ZERO_BIT  = 14;
  localparam int unsigned TIMER_EIGHT_BIT  = 19;
  localparam int unsigned TIMER_NINE_BIT   = 20;
  localparam int unsigned TIMER_TEN_BIT    = 21;

  // ****************************************************************
  // First-bus register fields
  // ****************************************************************
  localparam int unsigned TIMER_ONE_BIT      = 0;
  localparam int unsigned TIMER_TWO_BIT      = 1;
  localparam int unsigned TIMER_THREE_BIT    = 2;
  localparam int unsigned TIMER_FOUR_BIT     = 3;
  localparam int unsigned TIMER_FIVE_BIT     = 4;
  localparam int unsigned TIMER_SIX_BIT      = 5;
  localparam int unsigned TIMER_ELEVEN_BIT   = 6;
  localparam int unsigned TIMER_TWELVE_BIT   = 7;
  localparam int unsigned TIMER_THIRTEEN_BIT = 8;
  localparam int unsigned WINDOW_WATCHDOG_BIT = 11;
  localparam int unsigned SPI_ONE_BIT        = 14;
  localparam int unsigned SPI_TWO_BIT        = 15;
  localparam int unsigned SERIAL_ONE_BIT     = 17;
  localparam int unsigned SERIAL_TWO_BIT     = 18;
  localparam int unsigned SERIAL_THREE_BIT   = 19;
  localparam int unsigned SERIAL_FOUR_BIT    = 20;
  localparam int unsigned I2C_ZERO_BIT       = 21;
  localparam int unsigned I2C_ONE_BIT        = 22;
  localparam int unsigned CAN_ZERO_BIT       = 25;
  localparam int unsigned CAN_ONE_BIT        = 26;
  localparam int unsigned BACKUP_IF_BIT      = 27;
  localparam int unsigned POWER_CTRL_BIT     = 28;
  localparam int unsigned DAC_UNIT_BIT       = 29;

  // ****************************************************************
  // Bus answer state
  // ****************************************************************
  typedef enum logic [0:0] {BUS_IDLE, BUS_DONE} bus_state_type;

endpackage

// file: rtl/reset_word_reg.sv
// One byte-enabled reset-request word with a mask of writable bits.
// Assumes the caller decodes the address and gives a one-cycle write strobe.
`timescale 1ns/1ps
module reset_word_reg #(
  parameter logic [31:0] WRITE_MASK = 32'hFFFF_FFFF
) (
  input  wire logic        clk_sys,
  input  wire logic        rstSync_n,
  input  wire logic        writeStrobe,
  input  wire logic [3:0]  byteEnable,
  input  wire logic [31:0] writeData,
  output logic      [31:0] value
);

  logic [31:0] word_q;
  logic [31:0] word_d;

  // Each enabled byte lane replaced whole; reserved bits forced to zero
  always_comb
  begin
    word_d = word_q;
    if (writeStrobe)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (byteEnable[i])
        begin
          word_d[i*8 +: 8] = writeData[i*8 +: 8] & WRITE_MASK[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      word_q <= periph_reset_pkg::REG_RESET_VALUE;
    end
    else
    begin
      word_q <= word_d;
    end
  end

  assign value = word_q;

  // Only a write may change the stored word
  property p_hold_without_write;
    @(posedge clk_sys) disable iff (!rstSync_n)
    !writeStrobe |=> (word_q == $past(word_q));
  endproperty
  a_hold_without_write: assert property (p_hold_without_write) else $error("reset word changed without write");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (word_q & ~WRITE_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved reset bit set");

endmodule

// file: rtl/peripheral_reset_control.sv
// Peripheral reset control: two reset-request registers and their reset outputs.
// Assumes an Avalon-MM master on clk_sys and peripherals taking active-high reset levels.
//
// What this block does
// - Second-bus register at 0x0C, clears on reset
// - First-bus register at 0x10, clears on reset
// - Bits change only by software writes
// - Second bus: timers ten, nine, eight, seven and zero reset bits
// - Second bus: serial, SPI, converter resets
// - Bits 8..2 reset ports G..A
// - Bit 0 alternate-function reset; bit 1 reserved
// - First bus: DAC, power, backup resets
// - First bus: CAN one and zero
// - First bus: I2C one and zero
// - First bus: serial ports four..one
// - First bus: SPI two and one
// - First bus: bit 11 window watchdog
// - First bus: bits 8..1 timers
// - First bus: bit 0 timer one
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module peripheral_reset_control (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             timer_ten_reset_req,
  output logic             timer_nine_reset_req,
  output logic             timer_eight_reset_req,
  output logic             serial_zero_reset_req,
  output logic             timer_seven_reset_req,
  output logic             spi_zero_reset_req,
  output logic             timer_zero_reset_req,
  output logic             converter_one_reset_req,
  output logic             converter_zero_reset_req,
  output logic             port_g_reset_req,
  output logic             port_f_reset_req,
  output logic             port_e_reset_req,
  output logic             port_d_reset_req,
  output logic             port_c_reset_req,
  output logic             port_b_reset_req,
  output logic             port_a_reset_req,
  output logic             alt_function_reset_req,
  output logic             dac_unit_reset_req,
  output logic             power_ctrl_reset_req,
  output logic             backup_if_reset_req,
  output logic             can_one_reset_req,
  output logic             can_zero_reset_req,
  output logic             i2c_one_reset_req,
  output logic             i2c_zero_reset_req,
  output logic             serial_four_reset_req,
  output logic             serial_three_reset_req,
  output logic             serial_two_reset_req,
  output logic             serial_one_reset_req,
  output logic             spi_two_reset_req,
  output logic             spi_one_reset_req,
  output logic             window_watchdog_reset_req,
  output logic             timer_thirteen_reset_req,
  output logic             timer_twelve_reset_req,
  output logic             timer_eleven_reset_req,
  output logic             timer_six_reset_req,
  output logic             timer_five_reset_req,
  output logic             timer_four_reset_req,
  output logic             timer_three_reset_req,
  output logic             timer_two_reset_req,
  output logic             timer_one_reset_req
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta_q;
  logic rstSync_n;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // Every access answers one cycle after it is seen; the idle cycle keeps
  // readdata registered so it is stable at the acceptance edge.
  periph_reset_pkg::bus_state_type busState_q;
  periph_reset_pkg::bus_state_type busState_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic        hitLowSpeed;
  logic        hitSlow;
  logic        writeLowSpeed;
  logic        writeSlow;
  logic [31:0] lowSpeedValue;
  logic [31:0] slowValue;

  always_comb
  begin
    hitLowSpeed = 1'b0;
    hitSlow     = 1'b0;
    if (address == periph_reset_pkg::LOW_SPEED_BUS_UNIT_RESET_OFFSET)
    begin
      hitLowSpeed = 1'b1;
    end
    else if (address == periph_reset_pkg::SLOW_BUS_UNIT_RESET_OFFSET)
    begin
      hitSlow = 1'b1;
    end
  end

  always_comb
  begin
    busState_d    = busState_q;
    readdata_d    = readdata_q;
    writeLowSpeed = 1'b0;
    writeSlow     = 1'b0;
    case (busState_q)
      periph_reset_pkg::BUS_IDLE:
      begin
        if (read || write)
        begin
          busState_d = periph_reset_pkg::BUS_DONE;
          // Write lands at the same edge the master sees waitrequest low
          readdata_d = periph_reset_pkg::UNMAPPED_READ_VALUE;
          if (read && hitLowSpeed)
          begin
            readdata_d = lowSpeedValue;
          end
          else if (read && hitSlow)
          begin
            readdata_d = slowValue;
          end
        end
      end
      periph_reset_pkg::BUS_DONE:
      begin
        busState_d    = periph_reset_pkg::BUS_IDLE;
        writeLowSpeed = write && hitLowSpeed;
        writeSlow     = write && hitSlow;
      end
      default:
      begin
        busState_d = periph_reset_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      busState_q <= periph_reset_pkg::BUS_IDLE;
      readdata_q <= periph_reset_pkg::UNMAPPED_READ_VALUE;
    end
    else
    begin
      busState_q <= busState_d;
      readdata_q <= readdata_d;
    end
  end

  assign waitrequest = (busState_q != periph_reset_pkg::BUS_DONE);
  assign readdata    = readdata_q;

  // ****************************************************************
  // Reset-request registers
  // ****************************************************************
  // Reserved bits are masked off, so a careless write cannot reach them
  reset_word_reg #(
    .WRITE_MASK (periph_reset_pkg::LOW_SPEED_WRITE_MASK)
  ) u_low_speed_reg (
    .clk_sys     (clk_sys),
    .rstSync_n   (rstSync_n),
    .writeStrobe (writeLowSpeed),
    .byteEnable  (byteenable),
    .writeData   (writedata),
    .value       (lowSpeedValue)
  );

  reset_word_reg #(
    .WRITE_MASK (periph_reset_pkg::SLOW_WRITE_MASK)
  ) u_slow_reg (
    .clk_sys     (clk_sys),
    .rstSync_n   (rstSync_n),
    .writeStrobe (writeSlow),
    .byteEnable  (byteenable),
    .writeData   (writedata),
    .value       (slowValue)
  );

  // ****************************************************************
  // Reset outputs, straight from register bits
  // ****************************************************************
  assign timer_ten_reset_req      = lowSpeedValue[periph_reset_pkg::TIMER_TEN_BIT];
  assign timer_nine_reset_req     = lowSpeedValue[periph_reset_pkg::TIMER_NINE_BIT];
  assign timer_eight_reset_req    = lowSpeedValue[periph_reset_pkg::TIMER_EIGHT_BIT];
  assign timer_seven_reset_req    = lowSpeedValue[periph_reset_pkg::TIMER_SEVEN_BIT];
  assign timer_zero_reset_req     = lowSpeedValue[periph_reset_pkg::TIMER_ZERO_BIT];
  assign serial_zero_reset_req    = lowSpeedValue[periph_reset_pkg::SERIAL_ZERO_BIT];
  assign spi_zero_reset_req       = lowSpeedValue[periph_reset_pkg::SPI_ZERO_BIT];
  assign converter_one_reset_req  = lowSpeedValue[periph_reset_pkg::CONVERTER_ONE_BIT];
  assign converter_zero_reset_req = lowSpeedValue[periph_reset_pkg::CONVERTER_ZERO_BIT];
  assign port_g_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_G_BIT];
  assign port_f_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_F_BIT];
  assign port_e_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_E_BIT];
  assign port_d_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_D_BIT];
  assign port_c_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_C_BIT];
  assign port_b_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_B_BIT];
  assign port_a_reset_req         = lowSpeedValue[periph_reset_pkg::PORT_A_BIT];
  assign alt_function_reset_req   = lowSpeedValue[periph_reset_pkg::ALT_FUNCTION_BIT];

  assign dac_unit_reset_req        = slowValue[periph_reset_pkg::DAC_UNIT_BIT];
  assign power_ctrl_reset_req      = slowValue[periph_reset_pkg::POWER_CTRL_BIT];
  assign backup_if_reset_req       = slowValue[periph_reset_pkg::BACKUP_IF_BIT];
  assign can_one_reset_req         = slowValue[periph_reset_pkg::CAN_ONE_BIT];
  assign can_zero_reset_req        = slowValue[periph_reset_pkg::CAN_ZERO_BIT];
  assign i2c_one_reset_req         = slowValue[periph_reset_pkg::I2C_ONE_BIT];
  assign i2c_zero_reset_req        = slowValue[periph_reset_pkg::I2C_ZERO_BIT];
  assign serial_four_reset_req     = slowValue[periph_reset_pkg::SERIAL_FOUR_BIT];
  assign serial_three_reset_req    = slowValue[periph_reset_pkg::SERIAL_THREE_BIT];
  assign serial_two_reset_req      = slowValue[periph_reset_pkg::SERIAL_TWO_BIT];
  assign serial_one_reset_req      = slowValue[periph_reset_pkg::SERIAL_ONE_BIT];
  assign spi_two_reset_req         = slowValue[periph_reset_pkg::SPI_TWO_BIT];
  assign spi_one_reset_req         = slowValue[periph_reset_pkg::SPI_ONE_BIT];
  assign window_watchdog_reset_req = slowValue[periph_reset_pkg::WINDOW_WATCHDOG_BIT];
  assign timer_thirteen_reset_req  = slowValue[periph_reset_pkg::TIMER_THIRTEEN_BIT];
  assign timer_twelve_reset_req    = slowValue[periph_reset_pkg::TIMER_TWELVE_BIT];
  assign timer_eleven_reset_req    = slowValue[periph_reset_pkg::TIMER_ELEVEN_BIT];
  assign timer_six_reset_req       = slowValue[periph_reset_pkg::TIMER_SIX_BIT];
  assign timer_five_reset_req      = slowValue[periph_reset_pkg::TIMER_FIVE_BIT];
  assign timer_four_reset_req      = slowValue[periph_reset_pkg::TIMER_FOUR_BIT];
  assign timer_three_reset_req     = slowValue[periph_reset_pkg::TIMER_THREE_BIT];
  assign timer_two_reset_req       = slowValue[periph_reset_pkg::TIMER_TWO_BIT];
  assign timer_one_reset_req       = slowValue[periph_reset_pkg::TIMER_ONE_BIT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_low_speed_reset_clear;
    @(posedge clk_sys) $rose(rstSync_n) |-> (lowSpeedValue == 32'h0000_0000);
  endproperty
  a_low_speed_reset_clear: assert property (p_low_speed_reset_clear) else $error("second-bus reg not clear");

  property p_slow_reset_clear;
    @(posedge clk_sys) $rose(rstSync_n) |-> (slowValue == 32'h0000_0000);
  endproperty
  a_slow_reset_clear: assert property (p_slow_reset_clear) else $error("first-bus reg not clear");

  property p_answer_one_cycle;
    @(posedge clk_sys) disable iff (!rstSync_n)
    ((read || write) && waitrequest) |=> !waitrequest;
  endproperty
  a_answer_one_cycle: assert property (p_answer_one_cycle) else $error("no answer after one wait cycle");

  property p_write_low_speed;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (write && !waitrequest && hitLowSpeed && byteenable == 4'hF)
      |=> (lowSpeedValue == ($past(writedata) & periph_reset_pkg::LOW_SPEED_WRITE_MASK));
  endproperty
  a_write_low_speed: assert property (p_write_low_speed) else $error("second-bus write lost");

  property p_timer_ten_level;
    @(posedge clk_sys) disable iff (!rstSync_n)
    timer_ten_reset_req == lowSpeedValue[21];
  endproperty
  a_timer_ten_level: assert property (p_timer_ten_level) else $error("timer ten reset mismatch");

  property p_port_a_level;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (port_a_reset_req == lowSpeedValue[2]) && (port_g_reset_req == lowSpeedValue[8]);
  endproperty
  a_port_a_level: assert property (p_port_a_level) else $error("port reset mismatch");

  property p_reserved_bit_one;
    @(posedge clk_sys) disable iff (!rstSync_n)
    lowSpeedValue[1] == 1'b0;
  endproperty
  a_reserved_bit_one: assert property (p_reserved_bit_one) else $error("reserved bit 1 set");

  property p_watchdog_level;
    @(posedge clk_sys) disable iff (!rstSync_n)
    window_watchdog_reset_req == slowValue[11];
  endproperty
  a_watchdog_level: assert property (p_watchdog_level) else $error("watchdog reset mismatch");

  property p_write_slow_reaches_output;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (write && !waitrequest && hitSlow && byteenable[0])
      |=> (timer_one_reset_req == $past(writedata[0]));
  endproperty
  a_write_slow_reaches_output: assert property (p_write_slow_reaches_output) else $error("timer one reset wrong");

  property p_read_returns_value;
    @(posedge clk_sys) disable iff (!rstSync_n)
    (read && !waitrequest && hitSlow) |-> (readdata == slowValue);
  endproperty
  a_read_returns_value: assert property (p_read_returns_value) else $error("read data mismatch");

endmodule

// file: test/periph_reset_sink.sv
// Behavioural far side: peripheral units that follow their reset levels.
// Assumes active-high reset levels from the block, sampled on clk_sys.
`timescale 1ns/1ps
module periph_reset_sink (
  input  wire logic        clk_sys,
  input  wire logic [31:0] lowReq,
  input  wire logic [31:0] slowReq,
  output logic      [31:0] lowHeld,
  output logic      [31:0] slowHeld
);
  // A unit sits in reset for every cycle its level is seen high
  always_ff @(posedge clk_sys)
  begin
    lowHeld  <= lowReq;
    slowHeld <= slowReq;
  end
endmodule

// file: test/test_peripheral_reset_control.sv
// Self-checking bench for the peripheral reset control block.
// Assumes one clk_sys domain and an Avalon-MM port with one wait cycle.
`timescale 1ns/1ps
module test_peripheral_reset_control;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic t10, t9, t8, s0, t7, sp0, t0, c1, c0, pg, pf, pe, pd, pc, pb, pa, af;
  logic dac, pwr, bkp, cn1, cn0, i1, i0, s4, s3, s2, s1, sp2, sp1, wd;
  logic t13, t12, t11, t6, t5, t4, t3, t2, t1;
  logic [31:0] lowOut, slowOut, lowHeld, slowHeld;
  int mismatches = 0;
  int compares = 0;
  // Writable bits worked out from the bit assignments
  localparam logic [31:0] LOW_BITS  = 32'h0038_7FFD;
  localparam logic [31:0] SLOW_BITS = 32'h3E7E_C9FF;

  always #2.5 clk_sys = ~clk_sys;

  assign lowOut = {10'h000, t10, t9, t8, 4'h0, s0, t7, sp0, t0, c1, c0, pg, pf, pe, pd, pc, pb, pa, 1'b0, af};
  assign slowOut = {2'h0, dac, pwr, bkp, cn1, cn0, 2'h0, i1, i0, s4, s3, s2, s1, 1'b0, sp2, sp1, 2'h0, wd,
                    2'h0, t13, t12, t11, t6, t5, t4, t3, t2, t1};

  peripheral_reset_control u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer_ten_reset_req(t10), .timer_nine_reset_req(t9), .timer_eight_reset_req(t8),
    .serial_zero_reset_req(s0), .timer_seven_reset_req(t7), .spi_zero_reset_req(sp0),
    .timer_zero_reset_req(t0), .converter_one_reset_req(c1), .converter_zero_reset_req(c0),
    .port_g_reset_req(pg), .port_f_reset_req(pf), .port_e_reset_req(pe), .port_d_reset_req(pd),
    .port_c_reset_req(pc), .port_b_reset_req(pb), .port_a_reset_req(pa), .alt_function_reset_req(af),
    .dac_unit_reset_req(dac), .power_ctrl_reset_req(pwr), .backup_if_reset_req(bkp),
    .can_one_reset_req(cn1), .can_zero_reset_req(cn0), .i2c_one_reset_req(i1), .i2c_zero_reset_req(i0),
    .serial_four_reset_req(s4), .serial_three_reset_req(s3), .serial_two_reset_req(s2),
    .serial_one_reset_req(s1), .spi_two_reset_req(sp2), .spi_one_reset_req(sp1),
    .window_watchdog_reset_req(wd), .timer_thirteen_reset_req(t13), .timer_twelve_reset_req(t12),
    .timer_eleven_reset_req(t11), .timer_six_reset_req(t6), .timer_five_reset_req(t5),
    .timer_four_reset_req(t4), .timer_three_reset_req(t3), .timer_two_reset_req(t2),
    .timer_one_reset_req(t1)
  );

  periph_reset_sink u_sink (
    .clk_sys(clk_sys), .lowReq(lowOut), .slowReq(slowOut), .lowHeld(lowHeld), .slowHeld(slowHeld)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Starts one edge after the caller, so strobes are never set twice in one step
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      $display("unexpected at %0t: no answer on the bus", $time);
      tally_and_finish();
    end
    else
    begin
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task automatic readCheck(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    access(1'b0, a, 32'h0000_0000, 4'hF, rd);
    check(rd, exp, what);
  endtask

  task automatic pinsCheck(input logic [31:0] lowExp, input logic [31:0] slowExp);
    @(posedge clk_sys);
    check(lowOut, lowExp, "low bus levels");
    check(slowOut, slowExp, "slow bus levels");
    @(posedge clk_sys);
    check(lowHeld, lowExp, "low units held");
    check(slowHeld, slowExp, "slow units held");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic resetValues;
    pinsCheck(32'h0000_0000, 32'h0000_0000);
    readCheck(8'h0C, 32'h0000_0000, "low reg after reset");
    readCheck(8'h10, 32'h0000_0000, "slow reg after reset");
  endtask

  // Reserved bits are always written as zero
  task automatic walkBits(input logic [7:0] a, input logic [31:0] m, input logic isLow);
    logic [31:0] rd;
    logic [31:0] v;
    for (int i = 0; i < 32; i++)
    begin
      if (m[i])
      begin
        v = 32'h0000_0001 << i;
        access(1'b1, a, v, 4'hF, rd);
        if (isLow)
          pinsCheck(v, 32'h0000_0000);
        else
          pinsCheck(32'h0000_0000, v);
        readCheck(a, v, "walked bit read");
      end
    end
    access(1'b1, a, 32'h0000_0000, 4'hF, rd);
    pinsCheck(32'h0000_0000, 32'h0000_0000);
  endtask

  task automatic lanesAndHold;
    logic [31:0] rd;
    access(1'b1, 8'h0C, LOW_BITS, 4'h2, rd);
    access(1'b1, 8'h10, SLOW_BITS, 4'h9, rd);
    pinsCheck(32'h0000_7F00, 32'h3E00_00FF);
    repeat (6) @(posedge clk_sys);
    readCheck(8'h0C, 32'h0000_7F00, "low lane kept");
    readCheck(8'h10, 32'h3E00_00FF, "slow lanes kept");
  endtask

  task automatic unmappedAndReset;
    logic [31:0] rd;
    access(1'b1, 8'h14, 32'hFFFF_FFFF, 4'hF, rd);
    access(1'b1, 8'h0C, LOW_BITS, 4'hF, rd);
    readCheck(8'h14, 32'h0000_0000, "unmapped read");
    pinsCheck(LOW_BITS, 32'h3E00_00FF);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    pinsCheck(32'h0000_0000, 32'h0000_0000);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    readCheck(8'h0C, 32'h0000_0000, "low reg after second reset");
    readCheck(8'h10, 32'h0000_0000, "slow reg after second reset");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    resetValues();
    walkBits(8'h0C, LOW_BITS, 1'b1);
    walkBits(8'h10, SLOW_BITS, 1'b0);
    lanesAndHold();
    unmappedAndReset();
    tally_and_finish();
  end
endmodule
